// ===== bench/mrsm_midi_src.sv
module mrsm_midi_src (
  // clock
  input wire logic clk,
  // parsed message out
  output logic msg_valid,
  output logic [7:0] msg_status,
  output logic [6:0] msg_d1,
  output logic [6:0] msg_d2
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    msg_valid = 1'b0;
    {msg_status, msg_d1, msg_d2} = '0;
  end
  // gap: idle cycles before the message
  task automatic send(input logic [7:0] st, input logic [6:0] a,
      input logic [6:0] b, input int gap = 0);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_status <= st;
    msg_d1 <= a;
    msg_d2 <= b;
    @(posedge clk);
    msg_valid <= 1'b0;
    // released: inverse, not a stale copy
    msg_status <= ~st;
    msg_d1 <= ~a;
    msg_d2 <= ~b;
    #1;
  endtask
endmodule // mrsm_midi_src

// ===== bench/mrsm_sva.sv
module mrsm_sva
  import mrsm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register writes
  input wire logic [5:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  // midi in and pads
  input wire logic msg_valid,
  input wire logic [7:0] msg_status,
  input wire logic [6:0] msg_d1,
  input wire logic [6:0] msg_d2,
  input wire logic pad_valid,
  // results
  input wire logic snd_valid,
  input wire logic [6:0] snd_vel,
  input wire logic seq_valid,
  input wire logic [7:0] seq_status,
  input wire logic alt_param,
  input wire logic kits_enabled,
  input wire logic song_sel_valid,
  input wire logic song_is_song,
  input wire logic [6:0] song_sel_num,
  input wire logic tx_valid,
  input wire logic [7:0] tx_status,
  input wire logic tx_bus
);
  // ==========
  // settings shadowed from the write strobe
  logic [9:0] ctrl;
  logic [3:0] rxch;
  logic [5:0] outch;
  logic [6:0] vel;
  logic [1:0] mode;
  logic live, ok, nok, cc, song_en;
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      rxch <= 4'h0;
      outch <= 6'h00;
      vel <= 7'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: ctrl <= reg_wdata[9:0];
        ADDR_RXCH: rxch <= reg_wdata[3:0];
        ADDR_OUTCH: outch <= reg_wdata[5:0];
        ADDR_VEL: vel <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end
  assign mode = ctrl[1:0];
  // sound modes only count while input is routed to the sounds
  assign live = !ctrl[CTRL_ROUTE_SEQ] &&
      (mode == MRSM_OMNI || mode == MRSM_POLY);
  assign ok = live && (mode == MRSM_OMNI || msg_status[3:0] == rxch);
  assign nok = msg_valid && msg_status[7:5] == 3'b100 && ok;
  assign cc = msg_valid && msg_status[7:4] == 4'hb;
  assign song_en = ctrl[CTRL_SONG_EN];
  // ==========
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_pad;
    pad_valid && outch[5] && live;
  endsequence
  sequence s_tx_pad;
    tx_valid && tx_status == {4'h9, outch[3:0]} && tx_bus == outch[4];
  endsequence
  sequence s_song_in;
    msg_valid && msg_status == 8'hf3 && song_en &&
      msg_d1 > SONG_BASE && msg_d1 <= SONG_MAX;
  endsequence
  a_note_taken: assert property (
    msg_valid && msg_status[7:4] == 4'h9 && msg_d2 != 7'h00 && ok
    |=> snd_valid) else $error("note dropped");
  a_chan_filter: assert property (
    snd_valid && mode != MRSM_MAPPED |-> $past(nok))
    else $error("filtered note played");
  a_vel_default: assert property (
    snd_valid && vel != 7'h00 |-> snd_vel == vel)
    else $error("default vel lost");
  a_seq_copy: assert property (
    seq_valid |-> $past(msg_valid) && seq_status == $past(msg_status))
    else $error("seq copy differs");
  a_seq_route: assert property (
    msg_valid && ctrl[CTRL_ROUTE_SEQ] && msg_status[7] &&
    msg_status[7:4] != 4'hf |=> seq_valid) else $error("seq missed message");
  a_kits_off: assert property (
    ctrl[CTRL_ROUTE_SEQ] |-> !kits_enabled)
    else $error("kits on in seq route");
  a_tx_silent: assert property (
    tx_valid && tx_status[7:4] == 4'h9 && mode != MRSM_MAPPED
    |-> outch[5]) else $error("pad sent with out off");
  a_pad_chan: assert property (
    s_pad |=> s_tx_pad) else $error("pad chan or bus wrong");
  a_song_map: assert property (
    s_song_in |=> song_sel_valid && song_is_song &&
    song_sel_num == $past(msg_d1) - SONG_BASE)
    else $error("song number not mapped");
  a_song_gate: assert property (
    song_sel_valid |-> $past(song_en) && $past(msg_valid))
    else $error("song select while disabled");
  a_hold_on: assert property (
    cc && msg_d1 == 7'h40 && ctrl[CTRL_HOLD_EN] && mode == MRSM_OMNI &&
    live |=> alt_param == ($past(msg_d2) > 7'h3f))
    else $error("hold pedal not followed");
  a_hold_off: assert property (
    !ctrl[CTRL_HOLD_EN] |=> $stable(alt_param))
    else $error("alt moved, hold off");
endmodule // mrsm_sva

// ===== bench/tb_midi_receive_sound_mapper.sv
module tb_midi_receive_sound_mapper
  import mrsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  typedef struct packed {
    logic [9:0] ctrl;
    logic [6:0] vel;
    logic [7:0] st;
    logic ev;
    logic eseq;
    logic [6:0] evel;
  } mrsm_row_s;
  logic clk, reset, reg_wr, reg_rd, pad_valid, msg_prev_sound;
  logic local_song_valid, local_song_is_song, msg_valid;
  logic [5:0] reg_addr;
  logic [63:0] reg_wdata, reg_rdata, rdv;
  logic [7:0] msg_status, seq_status, tx_status;
  logic [6:0] msg_d1, msg_d2, snd_vel, master_vol, next_level, mod_value;
  logic [6:0] song_sel_num, pad_key, pad_vel, local_song_num, tx_d1;
  logic [4:0] snd_num, pad_sound;
  logic [2:0] mod_dest;
  logic [1:0] dyn_source;
  logic snd_valid, seq_valid, alt_param, mod_valid, kits_enabled;
  logic skey_trig, song_sel_valid, song_is_song, tx_valid, tx_bus;
  logic [31:0] hits;
  int n_mismatch, cmp_count, k;
  mrsm_row_s rows [7] = '{
    '{10'h001, 7'h00, 8'h93, 1'b1, 1'b0, 7'h64},
    '{10'h002, 7'h00, 8'h94, 1'b1, 1'b0, 7'h64},
    '{10'h002, 7'h00, 8'h93, 1'b0, 1'b0, 7'h00},
    '{10'h000, 7'h00, 8'h94, 1'b0, 1'b0, 7'h00},
    '{10'h001, 7'h01, 8'h9f, 1'b1, 1'b0, 7'h01},
    '{10'h005, 7'h00, 8'h99, 1'b0, 1'b1, 7'h00},
    '{10'h002, 7'h7f, 8'h94, 1'b1, 1'b0, 7'h7f}};
  always #10 clk = ~clk;
  mrsm_midi_src src_u (.clk, .msg_valid, .msg_status, .msg_d1, .msg_d2);
  mrsm_mapper dut_u (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .msg_valid, .msg_status, .msg_d1, .msg_d2, .msg_prev_sound,
    .snd_valid, .snd_num, .snd_on(), .snd_key(), .snd_vel, .snd_bus(),
    .seq_valid, .seq_status, .seq_d1(), .seq_d2(), .master_vol,
    .next_level, .next_level_valid(), .alt_param, .mod_value, .mod_dest,
    .mod_valid, .dyn_source, .kit_left(), .kit_right(), .kits_enabled,
    .skey_trig, .song_sel_valid, .song_is_song, .song_sel_num, .pad_valid,
    .pad_sound, .pad_key, .pad_vel, .local_song_valid, .local_song_is_song,
    .local_song_num, .tx_valid, .tx_status, .tx_d1, .tx_d2(), .tx_bus);
  // ==========
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask
  task automatic pad(input logic [4:0] s);
    @(posedge clk);
    pad_valid <= 1'b1;
    pad_sound <= s;
    @(posedge clk);
    pad_valid <= 1'b0;
    #1;
  endtask
  task automatic lsong(input logic [6:0] n);
    @(posedge clk);
    local_song_valid <= 1'b1;
    local_song_is_song <= 1'b1;
    local_song_num <= n;
    @(posedge clk);
    local_song_valid <= 1'b0;
    #1;
  endtask
  // map entry on channel 2, keys 56..64 around root 60
  function automatic logic [63:0] mk(input logic [4:0] s, input logic b);
    return {31'h0, 1'b0, 7'h38, 7'h40, 7'h3c, s, b, 1'b1, 4'h1};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  // ==========
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {reg_wr, reg_rd, pad_valid, local_song_valid, local_song_is_song} = '0;
    {reg_addr, reg_wdata, pad_sound, local_song_num} = '0;
    pad_key = 7'h3c;
    pad_vel = 7'h50;
    msg_prev_sound = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CTRL);
    chk(rdv, 64'h004);
    chk(kits_enabled, 1'b0);
    chk(master_vol, 7'h7f);
    rd(6'h10);
    chk(rdv, 64'h0);
    $display("test reset done");
    wr(ADDR_RXCH, 64'h4);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, 64'(rows[i].ctrl));
      wr(ADDR_VEL, 64'(rows[i].vel));
      src_u.send(rows[i].st, 7'h3c, 7'h64, i);
      chk(snd_valid, rows[i].ev);
      chk(seq_valid, rows[i].eseq);
      if (rows[i].ev) chk(snd_vel, rows[i].evel);
    end
    wr(ADDR_VEL, 64'h0);
    $display("test filter rows done");
    wr(ADDR_CTRL, 64'h20c);
    chk(dyn_source, MRSM_AR_PRESS);
    chk(skey_trig, 1'b1);
    chk(kits_enabled, 1'b0);
    // routed to sequencer: write refused
    wr(ADDR_MOD, 64'h2000);
    rd(ADDR_MOD);
    chk(rdv, 64'h0);
    wr(ADDR_CTRL, 64'h001);
    wr(ADDR_MOD, 64'h2000);
    rd(ADDR_MOD);
    chk(rdv, 64'h2000);
    src_u.send(8'hb0, 7'h01, 7'h40);
    chk({mod_valid, mod_value}, {1'b1, 7'h40});
    chk(mod_dest, MRSM_D_PITCH_DOWN);
    $display("modulator done");
    wr(ADDR_CTRL, 64'h081);
    src_u.send(8'hf3, 7'h69, 7'h00);
    chk({song_sel_valid, song_is_song, song_sel_num}, 9'h185);
    src_u.send(8'hf3, 7'h63, 7'h00);
    chk({song_sel_valid, song_is_song, song_sel_num}, 9'h163);
    lsong(7'h07);
    chk({tx_valid, tx_status, tx_d1}, 16'hf9eb);
    wr(ADDR_CTRL, 64'h001);
    src_u.send(8'hf3, 7'h05, 7'h00);
    chk(song_sel_valid, 1'b0);
    $display("test song select done");
    wr(ADDR_CTRL, 64'h051);
    src_u.send(8'hb4, 7'h40, 7'h7f);
    chk(alt_param, 1'b1);
    src_u.send(8'hb4, 7'h07, 7'h20);
    chk(master_vol, 7'h20);
    wr(ADDR_CTRL, 64'h021);
    src_u.send(8'hb4, 7'h40, 7'h00);
    chk(alt_param, 1'b1);
    src_u.send(8'hb4, 7'h07, 7'h30);
    chk({master_vol, next_level}, 14'h1030);
    $display("hold volume done");
    wr(ADDR_OUTCH, 64'h32);
    pad(5'h03);
    chk({tx_valid, tx_status, tx_bus}, 10'h325);
    wr(ADDR_OUTCH, 64'h12);
    pad(5'h03);
    chk(tx_valid, 1'b0);
    $display("test pad output done");
    wr(ADDR_CTRL, 64'h003);
    wr(ADDR_MAP_BASE + 6'h03, mk(5'h03, 1'b0));
    wr(ADDR_MAP_BASE + 6'h04, mk(5'h04, 1'b1));
    src_u.send(8'h91, 7'h3e, 7'h32);
    hits = 32'h0;
    k = 0;
    while (hits != 32'h18 && k < 40) begin
      @(posedge clk);
      #1;
      if (snd_valid === 1'b1) hits = hits | (32'h1 << snd_num);
      k++;
    end
    chk(hits, 32'h18);
    $display("mapping done");
    wrap_up();
  end
endmodule // tb_midi_receive_sound_mapper

bind mrsm_mapper mrsm_sva chk_u (.clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .msg_valid, .msg_status, .msg_d1, .msg_d2, .pad_valid,
  .snd_valid, .snd_vel, .seq_valid, .seq_status, .alt_param, .kits_enabled,
  .song_sel_valid, .song_is_song, .song_sel_num, .tx_valid, .tx_status,
  .tx_bus);

// ===== include/mrsm_pkg.sv
package mrsm_pkg;
  // ==========================================================
  // register offsets (word addresses on the plain port)
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_RXCH = 6'h01;
  localparam logic [5:0] ADDR_OUTCH = 6'h02;
  localparam logic [5:0] ADDR_VEL = 6'h03;
  localparam logic [5:0] ADDR_PROG = 6'h04;
  localparam logic [5:0] ADDR_MOD = 6'h05;
  localparam logic [5:0] ADDR_STATUS = 6'h06;
  localparam logic [5:0] ADDR_MAP_BASE = 6'h20;
  // ==========================================================
  // ctrl field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ROUTE_SEQ = 2;
  localparam int CTRL_SKEY = 3;
  localparam int CTRL_VOL_LSB = 4;
  localparam int CTRL_HOLD_EN = 6;
  localparam int CTRL_SONG_EN = 7;
  localparam int CTRL_AREP_LSB = 8;
  localparam logic [9:0] CTRL_RESET = 10'h004;
  // map entry fields
  localparam int MAP_CH_LSB = 0;
  localparam int MAP_ON = 4;
  localparam int MAP_BUS = 5;
  localparam int MAP_SND_LSB = 6;
  localparam int MAP_ROOT_LSB = 11;
  localparam int MAP_HI_LSB = 18;
  localparam int MAP_LO_LSB = 25;
  localparam int MAP_RATE42 = 32;
  localparam int MAP_W = 33;
  // ==========================================================
  // key limits (midi notes: a1 = 33, c7 = 96)
  localparam logic [6:0] KEY_ROOT_MIN = 7'h21;
  localparam logic [6:0] KEY_ROOT_MAX = 7'h60;
  localparam logic [6:0] HI_MAX_SLOW = 7'h0c;
  localparam logic [6:0] HI_MAX_FAST = 7'h07;
  localparam logic [6:0] LO_MAX_SLOW = 7'h13;
  localparam logic [6:0] LO_MAX_FAST = 7'h18;
  // song select ranges
  localparam logic [6:0] SONG_SEQ_MAX = 7'h63;
  localparam logic [6:0] SONG_BASE = 7'h64;
  localparam logic [6:0] SONG_MAX = 7'h70;
  // ==========================================================
  typedef enum logic [1:0] {
    MRSM_OFF, MRSM_OMNI, MRSM_POLY, MRSM_MAPPED
  } mrsm_mode_e;
  typedef enum logic [1:0] {
    MRSM_VOL_NONE, MRSM_VOL_MAIN, MRSM_VOL_LEVEL, MRSM_VOL_RSVD
  } mrsm_vol_e;
  typedef enum logic [1:0] {
    MRSM_AR_NONE, MRSM_AR_WHEEL, MRSM_AR_PRESS, MRSM_AR_RSVD
  } mrsm_arep_e;
  typedef enum logic [2:0] {
    MRSM_D_NONE, MRSM_D_PITCH_UP, MRSM_D_PITCH_DOWN, MRSM_D_PAN_RIGHT,
    MRSM_D_PAN_LEFT, MRSM_D_LEVEL_UP, MRSM_D_LEVEL_DOWN, MRSM_D_RSVD
  } mrsm_dest_e;
endpackage

// ===== rtl/mrsm_map_mem.sv
module mrsm_map_mem
  import mrsm_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int W = MAP_W
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port, data registered
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule // mrsm_map_mem

// ===== rtl/mrsm_mapper.sv
// Summary of operation
// (R1) poly mode accepts voice messages only on receive channel 1-16
// (R2) omni mode ignores the receive channel setting
// (R3) time-code id 1-127 filtered like a channel in poly mode
// (R4) output channel off: no pad events sent
// (R5) omni/poly pad events use output channel and bus; not mapped
// (R6) mapped sound with channel off answers no channel
// (R7) map bus letter ignored on receive; layered sounds both play
// (R8) map bus letter picks snd_bus of that sound's received notes
// (R9) map entry holds sound 1-32 and root key a1-c7
// (R10) high key at most +12 (16/31 khz) or +7 (42 khz) above root
// (R11) low key bounded by lower high key or -19/-24 below root
// (R12) 16 programs each assign kit 1-4 or bank a-d per octave
// (R13) single-key off needs sound and pitch key; on, sound key only
// (R14) sequencer route: auto-repeat dynamics none, wheel or pressure
// (R15) modulator assignments writable only when routed to sounds
// (R16) modulator drives pitch, pan or level, normal or inverted
// (R17) default velocity 1-127 replaces every received velocity
// (R18) midi volume ignored, master, or level of next sound
// (R19) hold pedal drives alternate parameters only when enabled
// (R20) song select both ways: 1-99 sequences, 101-112 songs
// (R21) omni mode takes sound control on every channel
// (R22) sequencer route disables keyboard kits
// (R23) sequencer records messages from any channel
// (R24) channel is low four bits of the status byte
module mrsm_mapper
  import mrsm_pkg::*;
#(
  parameter int SOUNDS = 32,
  parameter int PROGS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  // incoming midi message, one cycle strobe
  input wire logic msg_valid,
  input wire logic [7:0] msg_status,
  input wire logic [6:0] msg_d1,
  input wire logic [6:0] msg_d2,
  input wire logic msg_prev_sound,
  // sound core side
  output logic snd_valid,
  output logic [4:0] snd_num,
  output logic snd_on,
  output logic [6:0] snd_key,
  output logic [6:0] snd_vel,
  output logic snd_bus,
  output logic seq_valid,
  output logic [7:0] seq_status,
  output logic [6:0] seq_d1,
  output logic [6:0] seq_d2,
  output logic [6:0] master_vol,
  output logic [6:0] next_level,
  output logic next_level_valid,
  output logic alt_param,
  output logic [6:0] mod_value,
  output logic [2:0] mod_dest,
  output logic mod_valid,
  output logic [1:0] dyn_source,
  output logic [3:0] kit_left,
  output logic [3:0] kit_right,
  output logic kits_enabled,
  output logic skey_trig,
  output logic song_sel_valid,
  output logic song_is_song,
  output logic [6:0] song_sel_num,
  // local pad events and song selection to transmit
  input wire logic pad_valid,
  input wire logic [4:0] pad_sound,
  input wire logic [6:0] pad_key,
  input wire logic [6:0] pad_vel,
  input wire logic local_song_valid,
  input wire logic local_song_is_song,
  input wire logic [6:0] local_song_num,
  output logic tx_valid,
  output logic [7:0] tx_status,
  output logic [6:0] tx_d1,
  output logic [6:0] tx_d2,
  output logic tx_bus
);
  // ==========================================================
  // configuration registers
  logic [9:0] ctrl;
  logic [3:0] rx_chan;
  logic [6:0] rx_id;
  logic out_on;
  logic [3:0] out_chan;
  logic out_bus;
  logic [6:0] def_vel;
  logic [3:0] prog_sel;
  logic [3:0] kit_l [PROGS];
  logic [3:0] kit_r [PROGS];
  logic [1:0] mod_src [PROGS];
  logic [2:0] mod_dst [PROGS];
  logic [6:0] vol_level;

  mrsm_mode_e mode;
  mrsm_vol_e vol_mode;
  logic route_seq;
  assign mode = mrsm_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign vol_mode = mrsm_vol_e'(ctrl[CTRL_VOL_LSB +: 2]);
  assign route_seq = ctrl[CTRL_ROUTE_SEQ];

  logic wr_ctrl, wr_prog, wr_mod, map_we, map_ok;
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  assign wr_prog = reg_wr && reg_addr == ADDR_PROG;
  assign wr_mod = reg_wr && reg_addr == ADDR_MOD && !route_seq; // [R15]

  // map entry checks against root and rate limits
  logic [6:0] w_root, w_hi, w_lo, w_himax, w_lomax;
  assign w_root = reg_wdata[MAP_ROOT_LSB +: 7];
  assign w_hi = reg_wdata[MAP_HI_LSB +: 7];
  assign w_lo = reg_wdata[MAP_LO_LSB +: 7];
  assign w_himax = reg_wdata[MAP_RATE42] ? HI_MAX_FAST : HI_MAX_SLOW;
  assign w_lomax = reg_wdata[MAP_RATE42] ? LO_MAX_FAST : LO_MAX_SLOW;
  assign map_ok = w_root >= KEY_ROOT_MIN && w_root <= KEY_ROOT_MAX // [R9]
    && w_hi >= w_root && (w_hi - w_root) <= w_himax // [R10]
    && w_lo <= w_root && (w_root - w_lo) <= w_lomax; // [R11]
  // bad entries are dropped rather than clipped
  assign map_we = reg_wr && reg_addr[5] && map_ok;

  // ==========================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      rx_chan <= 4'h0;
      rx_id <= 7'h01;
      out_on <= 1'b0;
      out_chan <= 4'h0;
      out_bus <= 1'b0;
      def_vel <= 7'h00;
      prog_sel <= 4'h0;
    end else if (reg_wr) begin
      if (wr_ctrl) ctrl <= reg_wdata[9:0];
      if (reg_addr == ADDR_RXCH) begin
        rx_chan <= reg_wdata[3:0];
        if (reg_wdata[14:8] != 7'h00) rx_id <= reg_wdata[14:8]; // [R3]
      end
      if (reg_addr == ADDR_OUTCH) begin
        out_chan <= reg_wdata[3:0];
        out_bus <= reg_wdata[4];
        out_on <= reg_wdata[5];
      end
      if (reg_addr == ADDR_VEL) def_vel <= reg_wdata[6:0];
      if (wr_prog || wr_mod) prog_sel <= reg_wdata[3:0];
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < PROGS; gp++) begin : g_prog
      always_ff @(posedge clk) begin
        if (reset) begin
          kit_l[gp] <= 4'h0;
          kit_r[gp] <= 4'h4;
          mod_src[gp] <= 2'h0;
          mod_dst[gp] <= 3'h0;
        end else begin
          if (wr_prog && reg_wdata[3:0] == gp[3:0]) begin // [R12]
            kit_l[gp] <= {1'b0, reg_wdata[10:8]};
            kit_r[gp] <= {1'b0, reg_wdata[14:12]};
          end
          if (wr_mod && reg_wdata[3:0] == gp[3:0]) begin // [R16]
            mod_src[gp] <= reg_wdata[9:8];
            mod_dst[gp] <= reg_wdata[14:12];
          end
        end
      end
    end
  endgenerate

  assign kit_left = kit_l[prog_sel];
  assign kit_right = kit_r[prog_sel];
  assign kits_enabled = !route_seq && mode != MRSM_MAPPED; // [R22]
  assign skey_trig = ctrl[CTRL_SKEY]; // [R13]
  assign dyn_source = route_seq ? ctrl[CTRL_AREP_LSB +: 2] : 2'h0; // [R14]

  // ==========================================================
  // incoming message decode
  logic [3:0] m_chan;
  logic m_voice, m_note, m_noteon, m_cc, m_press, m_bend, m_song, m_mtc;
  logic chan_ok;
  assign m_chan = msg_status[3:0]; // [R24]
  assign m_voice = msg_status[7] && msg_status[7:4] != 4'hf;
  assign m_note = msg_status[7:5] == 3'b100;
  assign m_noteon = msg_status[7:4] == 4'h9 && msg_d2 != 7'h00;
  assign m_cc = msg_status[7:4] == 4'hb;
  assign m_press = msg_status[7:4] == 4'hd;
  assign m_bend = msg_status[7:4] == 4'he;
  assign m_song = msg_status == 8'hf3;
  assign m_mtc = msg_status == 8'hf0;

  always_comb begin
    unique case (mode)
      MRSM_OFF: chan_ok = 1'b0;
      MRSM_OMNI: chan_ok = 1'b1; // [R2] [R21]
      MRSM_POLY: chan_ok = m_chan == rx_chan; // [R1]
      MRSM_MAPPED: chan_ok = 1'b1;
    endcase
  end

  // velocity after default substitution
  logic [6:0] eff_vel;
  assign eff_vel = def_vel != 7'h00 ? def_vel : msg_d2; // [R17]

  // ==========================================================
  // map memory: one entry per sound, scanned after each note
  logic [4:0] scan_idx;
  logic scan_busy;
  logic [MAP_W-1:0] map_rd;
  logic [7:0] scan_status;
  logic [6:0] scan_key, scan_vel;
  logic scan_vld;
  logic [4:0] scan_num;

  mrsm_map_mem #(.DEPTH(SOUNDS), .AW(5), .W(MAP_W)) u_map (
    .clk(clk),
    .we(map_we),
    .waddr(reg_addr[4:0]),
    .wdata(reg_wdata[MAP_W-1:0]),
    .raddr(scan_idx),
    .rdata(map_rd)
  );

  // one entry per cycle; notes arriving mid-scan are not mapped
  always_ff @(posedge clk) begin
    if (reset) begin
      scan_busy <= 1'b0;
      scan_idx <= 5'h00;
      scan_vld <= 1'b0;
      scan_num <= 5'h00;
      scan_status <= 8'h00;
      scan_key <= 7'h00;
      scan_vel <= 7'h00;
    end else begin
      scan_vld <= scan_busy;
      scan_num <= scan_idx;
      if (!scan_busy && msg_valid && m_note && mode == MRSM_MAPPED
          && !route_seq) begin
        scan_busy <= 1'b1;
        scan_idx <= 5'h00;
        scan_status <= msg_status;
        scan_key <= msg_d1;
        scan_vel <= eff_vel;
      end else if (scan_busy) begin
        scan_idx <= scan_idx + 5'h01;
        if (scan_idx == 5'(SOUNDS - 1)) scan_busy <= 1'b0;
      end
    end
  end

  logic map_hit;
  assign map_hit = scan_vld && map_rd[MAP_ON] // [R6]
    && map_rd[MAP_CH_LSB +: 4] == scan_status[3:0] // [R7]
    && scan_key >= map_rd[MAP_LO_LSB +: 7]
    && scan_key <= map_rd[MAP_HI_LSB +: 7];

  // ==========================================================
  // sound core outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      snd_valid <= 1'b0;
      snd_num <= 5'h00;
      snd_on <= 1'b0;
      snd_key <= 7'h00;
      snd_vel <= 7'h00;
      snd_bus <= 1'b0;
    end else if (map_hit) begin
      snd_valid <= 1'b1;
      snd_num <= scan_num;
      snd_on <= scan_status[4] && scan_vel != 7'h00;
      snd_key <= scan_key;
      snd_vel <= scan_vel;
      snd_bus <= map_rd[MAP_BUS]; // [R8]
    end else if (msg_valid && m_note && chan_ok && !route_seq
                 && mode != MRSM_MAPPED) begin
      snd_valid <= 1'b1;
      snd_num <= msg_prev_sound ? snd_num : 5'h00;
      snd_on <= m_noteon;
      snd_key <= msg_d1;
      snd_vel <= eff_vel;
      snd_bus <= out_bus;
    end else begin
      snd_valid <= 1'b0;
    end
  end

  // sequencer path takes every channel
  always_ff @(posedge clk) begin
    if (reset) begin
      seq_valid <= 1'b0;
      seq_status <= 8'h00;
      seq_d1 <= 7'h00;
      seq_d2 <= 7'h00;
    end else begin
      seq_valid <= msg_valid && route_seq && m_voice; // [R23]
      seq_status <= msg_status;
      seq_d1 <= msg_d1;
      seq_d2 <= m_note ? eff_vel : msg_d2; // [R17]
    end
  end

  // ==========================================================
  // controllers: volume, hold pedal, modulators, time code id
  logic sc_ok;
  assign sc_ok = msg_valid && chan_ok && !route_seq;
  always_ff @(posedge clk) begin
    if (reset) begin
      master_vol <= 7'h7f;
      vol_level <= 7'h7f;
      next_level_valid <= 1'b0;
      alt_param <= 1'b0;
      mod_valid <= 1'b0;
      mod_value <= 7'h00;
      mod_dest <= 3'h0;
    end else begin
      mod_valid <= 1'b0;
      if (sc_ok && m_cc && msg_d1 == 7'h07) begin // [R18]
        if (vol_mode == MRSM_VOL_MAIN) master_vol <= msg_d2;
        if (vol_mode == MRSM_VOL_LEVEL) begin
          vol_level <= msg_d2;
          next_level_valid <= 1'b1;
        end
      end else if (snd_valid && snd_on) begin
        next_level_valid <= 1'b0;
      end
      if (sc_ok && m_cc && msg_d1 == 7'h40 && ctrl[CTRL_HOLD_EN]) begin
        alt_param <= msg_d2[6]; // [R19]
      end
      if (sc_ok && ((m_cc && msg_d1 == 7'h01 && mod_src[prog_sel] == 2'h0)
          || (m_bend && mod_src[prog_sel] == 2'h1)
          || (m_press && mod_src[prog_sel] == 2'h2))) begin // [R16]
        mod_valid <= mod_dst[prog_sel] != 3'h0;
        mod_dest <= mod_dst[prog_sel];
        mod_value <= m_press ? msg_d1 : msg_d2;
      end
    end
  end
  assign next_level = vol_level;

  // time code id match, seen in status
  logic mtc_seen;
  always_ff @(posedge clk) begin
    if (reset) mtc_seen <= 1'b0;
    else if (msg_valid && m_mtc && (mode != MRSM_POLY || msg_d1 == rx_id))
      mtc_seen <= 1'b1; // [R3]
  end

  // ==========================================================
  // song select, received
  always_ff @(posedge clk) begin
    if (reset) begin
      song_sel_valid <= 1'b0;
      song_is_song <= 1'b0;
      song_sel_num <= 7'h00;
    end else begin
      song_sel_valid <= 1'b0;
      if (msg_valid && m_song && ctrl[CTRL_SONG_EN]) begin // [R20]
        if (msg_d1 >= 7'h01 && msg_d1 <= SONG_SEQ_MAX) begin
          song_sel_valid <= 1'b1;
          song_is_song <= 1'b0;
          song_sel_num <= msg_d1;
        end else if (msg_d1 > SONG_BASE && msg_d1 <= SONG_MAX) begin
          song_sel_valid <= 1'b1;
          song_is_song <= 1'b1;
          song_sel_num <= msg_d1 - SONG_BASE;
        end
      end
    end
  end

  // transmit: song select first, then pad events
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_status <= 8'h00;
      tx_d1 <= 7'h00;
      tx_d2 <= 7'h00;
      tx_bus <= 1'b0;
    end else if (local_song_valid && ctrl[CTRL_SONG_EN]) begin // [R20]
      tx_valid <= 1'b1;
      tx_status <= 8'hf3;
      tx_d1 <= local_song_is_song ? local_song_num + SONG_BASE
                                  : local_song_num;
      tx_d2 <= 7'h00;
      tx_bus <= out_bus;
    end else if (pad_valid && out_on && mode != MRSM_OFF) begin // [R4]
      tx_valid <= 1'b1;
      tx_status <= {4'h9, mode == MRSM_MAPPED ? 4'h0 : out_chan}; // [R5]
      tx_d1 <= pad_key;
      tx_d2 <= pad_vel;
      tx_bus <= out_bus;
    end else begin
      tx_valid <= 1'b0;
    end
  end

  // ==========================================================
  // register read
  always_ff @(posedge clk) begin
    if (reset) reg_rdata <= 64'h0;
    else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: reg_rdata <= {54'h0, ctrl};
        ADDR_RXCH: reg_rdata <= {49'h0, rx_id, 4'h0, rx_chan};
        ADDR_OUTCH: reg_rdata <= {58'h0, out_on, out_bus, out_chan};
        ADDR_VEL: reg_rdata <= {57'h0, def_vel};
        ADDR_PROG: reg_rdata <= {49'h0, kit_right[2:0], 1'b0, kit_left[2:0],
                                 4'h0, prog_sel};
        ADDR_MOD: reg_rdata <= {49'h0, mod_dst[prog_sel], 2'h0,
                                mod_src[prog_sel], 4'h0, prog_sel};
        ADDR_STATUS: reg_rdata <= {61'h0, mtc_seen, scan_busy,
                                   next_level_valid};
        default: reg_rdata <= 64'h0;
      endcase
    end
  end
endmodule // mrsm_mapper
